// File: hw/host_bus_host.sv
// Host end of the parallel port: runs one bus cycle per user command in
// Intel or Motorola style, multiplexed or not, and drives the DMA pins.
// Assumes the device end samples pins through two flip-flops.
`timescale 1ns/1ns
`default_nettype none
module host_bus_host (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	host_bus_if.host bus,
	input wire logic motorola_mode_in,
	input wire logic mux_mode_in,
	input wire logic fast_timing_in,
	input wire logic device_reset_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic cmd_dma_in,
	input wire logic cmd_wide_in,
	input wire logic [2:0] cmd_addr_in,
	input wire logic [15:0] cmd_wdata_in,
	input wire logic tc_level_in,
	input wire logic refresh_n_in,
	output logic cmd_ready_out,
	output logic rsp_valid_out,
	output logic [15:0] rsp_rdata_out,
	output logic irq_out,
	output logic dma_request_seen_out,
	output logic wide_cycle_seen_out
);
	// Two-flop synchroniser for the device's pins
	logic [18:0] sync1_reg, sync2_reg, pins_raw;
	assign pins_raw = {bus.irq_out_n, bus.wide_cycle_indicator_n, bus.dma_request_out,
		bus.upper_byte_lines, bus.low_data_upper_bits, bus.low_shared_lines};
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			sync1_reg <= 19'h7ffff;
			sync2_reg <= 19'h7ffff;
		end
		else
		begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
		end
	end

	// Cycle sequencer
	host_bus_pkg::cycle_state_type state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic wr_reg, dma_reg, wide_reg;
	logic [2:0] addr_reg;
	logic [15:0] wdata_reg;
	logic last;
	assign last = (cnt_reg == 4'h0);
	always_comb
	begin
		state_next = state_reg;
		cnt_next = last ? 4'h0 : cnt_reg - 4'h1;
		case (state_reg)
			host_bus_pkg::ST_IDLE:
				if (cmd_valid_in && mux_mode_in && !cmd_dma_in)
				begin
					state_next = host_bus_pkg::ST_LATCH;
					cnt_next = 4'(host_bus_pkg::ALE_CYCLES - 1);
				end
				else if (cmd_valid_in)
				begin
					state_next = host_bus_pkg::ST_SETUP;
					cnt_next = 4'(host_bus_pkg::SETUP_CYCLES - 1);
				end
			host_bus_pkg::ST_LATCH:
				if (last)
				begin
					state_next = host_bus_pkg::ST_SETUP;
					cnt_next = 4'(host_bus_pkg::SETUP_CYCLES - 1);
				end
			host_bus_pkg::ST_SETUP:
				if (last)
				begin
					state_next = host_bus_pkg::ST_STROBE;
					cnt_next = 4'(host_bus_pkg::STROBE_CYCLES - 1);
				end
			host_bus_pkg::ST_STROBE:
				if (last)
				begin
					state_next = host_bus_pkg::ST_HOLD;
					cnt_next = 4'(host_bus_pkg::HOLD_CYCLES - 1);
				end
			host_bus_pkg::ST_HOLD:
				if (last)
					state_next = host_bus_pkg::ST_IDLE;
			default:
				state_next = host_bus_pkg::ST_IDLE;
		endcase
	end

	// Pin levels for the coming state
	logic in_cycle, strobe_on, latch_on, take;
	assign take = (state_reg == host_bus_pkg::ST_IDLE) && cmd_valid_in;
	assign in_cycle = (state_next != host_bus_pkg::ST_IDLE);
	assign strobe_on = (state_next == host_bus_pkg::ST_STROBE);
	assign latch_on = (state_next == host_bus_pkg::ST_LATCH);

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= host_bus_pkg::ST_IDLE;
			cnt_reg <= 4'h0;
			wr_reg <= 1'b0;
			dma_reg <= 1'b0;
			wide_reg <= 1'b0;
			addr_reg <= 3'h0;
			wdata_reg <= 16'h0000;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (take)
			begin
				wr_reg <= cmd_write_in;
				dma_reg <= cmd_dma_in;
				wide_reg <= cmd_wide_in;
				addr_reg <= cmd_addr_in;
				wdata_reg <= cmd_wdata_in;
			end
		end
	end

	// Registered pin drivers
	logic wr_now, dma_now, wide_now;
	logic [2:0] addr_now;
	logic [15:0] wdata_now;
	assign wr_now = take ? cmd_write_in : wr_reg;
	assign dma_now = take ? cmd_dma_in : dma_reg;
	assign wide_now = take ? cmd_wide_in : wide_reg;
	assign addr_now = take ? cmd_addr_in : addr_reg;
	assign wdata_now = take ? cmd_wdata_in : wdata_reg;
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			bus.chip_select_n <= 1'b1;
			bus.dma_ack_n <= 1'b1;
			bus.read_or_data_strobe <= 1'b1;
			bus.write_or_rw_sense <= 1'b1;
			bus.addr_bit_zero_mux_sel <= 1'b0;
			bus.addr_bit_one <= 1'b1;
			bus.addr_bit_two_latch <= 1'b0;
			bus.host_low_out <= 8'h00;
			bus.host_low_oe <= 1'b0;
			bus.host_up_out <= 8'h00;
			bus.host_up_oe <= 1'b0;
			bus.hw_reset_n <= 1'b0;
			bus.timing_select <= 1'b1;
			bus.terminal_count_in <= 1'b0;
			bus.refresh_event_n <= 1'b1;
		end
		else
		begin
			bus.chip_select_n <= !(in_cycle && !dma_now);
			bus.dma_ack_n <= !(in_cycle && dma_now);
			bus.read_or_data_strobe <= motorola_mode_in ? !strobe_on :
				!(strobe_on && !wr_now);
			bus.write_or_rw_sense <= motorola_mode_in ? !(in_cycle && wr_now) :
				!(strobe_on && wr_now);
			bus.addr_bit_zero_mux_sel <= mux_mode_in ? 1'b0 : addr_now[0];
			bus.addr_bit_one <= mux_mode_in ? 1'b1 : addr_now[1];
			bus.addr_bit_two_latch <= mux_mode_in ? latch_on : addr_now[2];
			bus.host_low_out <= latch_on ? {5'h00, addr_now} : wdata_now[7:0];
			bus.host_low_oe <= latch_on || (in_cycle && wr_now);
			bus.host_up_out <= wdata_now[15:8];
			bus.host_up_oe <= in_cycle && wr_now && wide_now && !latch_on;
			bus.hw_reset_n <= !device_reset_in;
			bus.timing_select <= !(fast_timing_in && !mux_mode_in);
			bus.terminal_count_in <= tc_level_in;
			bus.refresh_event_n <= refresh_n_in;
		end
	end

	// User-side answers
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			cmd_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= 16'h0000;
			irq_out <= 1'b0;
			dma_request_seen_out <= 1'b0;
			wide_cycle_seen_out <= 1'b0;
		end
		else
		begin
			cmd_ready_out <= (state_next == host_bus_pkg::ST_IDLE);
			rsp_valid_out <= (state_reg == host_bus_pkg::ST_STROBE) && last && !wr_reg;
			if ((state_reg == host_bus_pkg::ST_STROBE) && last && !wr_reg)
				rsp_rdata_out <= wide_reg ? sync2_reg[15:0] : {8'h00, sync2_reg[7:0]};
			irq_out <= !sync2_reg[18];
			wide_cycle_seen_out <= !sync2_reg[17];
			dma_request_seen_out <= sync2_reg[16];
		end
	end
endmodule
`default_nettype wire

// File: hw/host_bus_pkg.sv
// Shared constants for both ends of the parallel host port.
// Assumes one 20 MHz clock on each end and pins joined by host_bus_if.
package host_bus_pkg;
	// Pin field widths
	localparam int ADDR_W = 3;
	localparam int BYTE_W = 8;
	// Synchroniser depth for every pin input
	localparam int SYNC_STAGES = 2;
	// Register index of the data register that may be 16 bits wide
	localparam logic [2:0] DATA_REG_ADDR = 3'h4;
	// Host cycle timing, in clock cycles
	localparam int ALE_CYCLES = 2;
	localparam int SETUP_CYCLES = 1;
	localparam int STROBE_CYCLES = 8;
	localparam int HOLD_CYCLES = 2;
	// Values after reset
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] BUS_PULLUP = 8'hff;
	// Host cycle sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_LATCH = 5'h02,
		ST_SETUP = 5'h04,
		ST_STROBE = 5'h08,
		ST_HOLD = 5'h10
	} cycle_state_type;
endpackage

// File: hw/host_bus_if.sv
// Pin bundle between the host end and the device end of the parallel port.
// Resolves the shared data lines from both enables; idle lines read high.
`timescale 1ns/1ns
`default_nettype none
interface host_bus_if;
	// Host-driven pins
	logic addr_bit_zero_mux_sel;
	logic addr_bit_one;
	logic addr_bit_two_latch;
	logic write_or_rw_sense;
	logic read_or_data_strobe;
	logic hw_reset_n;
	logic chip_select_n;
	logic timing_select;
	logic dma_ack_n;
	logic terminal_count_in;
	logic refresh_event_n;
	logic [7:0] host_low_out;
	logic host_low_oe;
	logic [7:0] host_up_out;
	logic host_up_oe;
	// Device-driven pins
	logic irq_out_n;
	logic wide_cycle_indicator_n;
	logic dma_request_out;
	logic [7:0] dev_low_out;
	logic dev_low_oe;
	logic [7:0] dev_up_out;
	logic dev_up_oe;
	// Resolved shared lines, pulled up when nobody drives
	logic [2:0] low_shared_lines;
	logic [4:0] low_data_upper_bits;
	logic [7:0] upper_byte_lines;
	logic [7:0] low_byte;
	assign low_byte = dev_low_oe ? dev_low_out : (host_low_oe ? host_low_out : 8'hff);
	assign low_shared_lines = low_byte[2:0];
	assign low_data_upper_bits = low_byte[7:3];
	assign upper_byte_lines = dev_up_oe ? dev_up_out : (host_up_oe ? host_up_out : 8'hff);
	modport device (
		input addr_bit_zero_mux_sel, addr_bit_one, addr_bit_two_latch,
		input write_or_rw_sense, read_or_data_strobe, hw_reset_n, chip_select_n,
		input timing_select, dma_ack_n, terminal_count_in, refresh_event_n,
		input low_shared_lines, low_data_upper_bits, upper_byte_lines,
		output irq_out_n, wide_cycle_indicator_n, dma_request_out,
		output dev_low_out, dev_low_oe, dev_up_out, dev_up_oe
	);
	modport host (
		output addr_bit_zero_mux_sel, addr_bit_one, addr_bit_two_latch,
		output write_or_rw_sense, read_or_data_strobe, hw_reset_n, chip_select_n,
		output timing_select, dma_ack_n, terminal_count_in, refresh_event_n,
		output host_low_out, host_low_oe, host_up_out, host_up_oe,
		input low_shared_lines, low_data_upper_bits, upper_byte_lines,
		input irq_out_n, wide_cycle_indicator_n, dma_request_out
	);
endinterface
`default_nettype wire

// File: hw/host_bus_device.sv
// Device end of the parallel host port: decodes host cycles into register
// strobes, drives read data, and handles interrupt, DMA and refresh pins.
// Assumes the register file sits on the user side and answers combinationally.
//
// Contract
// - Non-mux mode: three address pins pick register
// - Mux mode: address latched from shared lines
// - Lines three to seven carry data only
// - Upper byte driven only for wide access
// - Wide access programmable; byte swapper between lanes
// - Intel mode: write pin is low write strobe
// - Motorola mode: direction pin, low write, high read
// - Read pin is read or data strobe
// - Active-low hardware reset pin resets device
// - Interrupt request leaves on active-low pin
// - Cycles answered only while chip select low; the code also answers while DMA acknowledge is low
// - Wide indicator low only on wide data access
// - Timing pin low selects fast non-mux timing
// - DMA request polarity programmable, default high
// - DMA controller acknowledges by pulling acknowledge low
// - Terminal count polarity programmable, default high
// - Refresh event sensed on falling edge
`timescale 1ns/1ns
`default_nettype none
module host_bus_device (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	host_bus_if.device bus,
	input wire logic motorola_mode_in,
	input wire logic mux_mode_in,
	input wire logic wide_enable_in,
	input wire logic swap_bytes_in,
	input wire logic dma_request_out_active_low_in,
	input wire logic tc_active_low_in,
	input wire logic irq_request_in,
	input wire logic dma_request_in,
	input wire logic [15:0] reg_rdata_in,
	output logic [2:0] reg_addr_out,
	output logic [15:0] reg_wdata_out,
	output logic reg_write_out,
	output logic reg_read_out,
	output logic dma_cycle_out,
	output logic terminal_count_out,
	output logic refresh_event_out,
	output logic fast_timing_out,
	output logic hw_reset_seen_out
);
	localparam int SYNC_W = 27;

	// Raw pin vector that passes the two-stage synchroniser
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	assign pins_raw = {bus.chip_select_n, bus.read_or_data_strobe, bus.write_or_rw_sense,
		bus.addr_bit_zero_mux_sel, bus.addr_bit_one, bus.addr_bit_two_latch,
		bus.dma_ack_n, bus.terminal_count_in, bus.refresh_event_n, bus.timing_select,
		bus.hw_reset_n, bus.upper_byte_lines, bus.low_data_upper_bits, bus.low_shared_lines};

	// Two flip-flops per pin before any logic looks at it
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			sync1_reg <= {SYNC_W{1'b1}};
			sync2_reg <= {SYNC_W{1'b1}};
		end
		else
		begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
		end
	end

	// Named views of the synchronised pins
	logic cs_n_s, strobe_n_s, wr_dir_s, a0_s, a1_s, addr_bit_two_latch_s;
	logic ack_n_s, tc_s, refex_n_s, tmg_s, hwrst_n_s;
	logic [7:0] up_s;
	logic [7:0] low_s;
	assign {cs_n_s, strobe_n_s, wr_dir_s, a0_s, a1_s, addr_bit_two_latch_s, ack_n_s, tc_s,
		refex_n_s, tmg_s, hwrst_n_s, up_s, low_s} = sync2_reg;

	// Internal reset: either the local reset or the host's reset pin
	logic rst;
	assign rst = !rst_n_in || !hwrst_n_s;

	// Cycle decode for both strobe styles
	logic selected, dma_sel, rd_act, wr_act;
	logic [2:0] addr_latch_reg;
	logic [2:0] cyc_addr;
	logic is_data, wide_hit;
	assign dma_sel = !ack_n_s;
	assign selected = !cs_n_s || dma_sel;
	assign rd_act = motorola_mode_in ?
		(selected && !strobe_n_s && wr_dir_s) :
		(selected && !strobe_n_s);
	assign wr_act = motorola_mode_in ?
		(selected && !strobe_n_s && !wr_dir_s) :
		(selected && !wr_dir_s);
	assign cyc_addr = dma_sel ? host_bus_pkg::DATA_REG_ADDR :
		(mux_mode_in ? addr_latch_reg : {addr_bit_two_latch_s, a1_s, a0_s});
	assign is_data = (cyc_addr == host_bus_pkg::DATA_REG_ADDR);
	assign wide_hit = wide_enable_in && is_data;

	// Address latch follows the shared lines while the latch strobe is high
	always_ff @(posedge mclk_in)
	begin
		if (rst)
			addr_latch_reg <= 3'h0;
		else if (mux_mode_in && addr_bit_two_latch_s)
			addr_latch_reg <= low_s[2:0];
	end

	// Read data lane selection through the swapper
	logic [7:0] rd_low, rd_up;
	assign rd_low = (swap_bytes_in && wide_hit) ? reg_rdata_in[15:8] : reg_rdata_in[7:0];
	assign rd_up = (swap_bytes_in && wide_hit) ? reg_rdata_in[7:0] : reg_rdata_in[15:8];

	// Write data assembly through the swapper
	logic [15:0] wr_word;
	assign wr_word = !wide_hit ? {8'h00, low_s} :
		(swap_bytes_in ? {low_s, up_s} : {up_s, low_s});

	// Data pin drivers
	logic [7:0] low_out_reg, up_out_reg;
	logic low_oe_reg, up_oe_reg;
	always_ff @(posedge mclk_in)
	begin
		if (rst)
		begin
			low_out_reg <= host_bus_pkg::BYTE_RESET;
			up_out_reg <= host_bus_pkg::BYTE_RESET;
			low_oe_reg <= 1'b0;
			up_oe_reg <= 1'b0;
		end
		else
		begin
			low_out_reg <= rd_low;
			up_out_reg <= rd_up;
			low_oe_reg <= rd_act;
			up_oe_reg <= rd_act && wide_hit;
		end
	end
	assign bus.dev_low_out = low_out_reg;
	assign bus.dev_low_oe = low_oe_reg;
	assign bus.dev_up_out = up_out_reg;
	assign bus.dev_up_oe = up_oe_reg;

	// Register strobes: read at cycle start, write at cycle end
	logic rd_prev_reg, wr_prev_reg;
	always_ff @(posedge mclk_in)
	begin
		if (rst)
		begin
			rd_prev_reg <= 1'b0;
			wr_prev_reg <= 1'b0;
			reg_addr_out <= 3'h0;
			reg_wdata_out <= 16'h0000;
			reg_read_out <= 1'b0;
			reg_write_out <= 1'b0;
			dma_cycle_out <= 1'b0;
		end
		else
		begin
			rd_prev_reg <= rd_act;
			wr_prev_reg <= wr_act;
			reg_read_out <= rd_act && !rd_prev_reg;
			reg_write_out <= wr_prev_reg && !wr_act;
			if (rd_act || wr_act)
			begin
				reg_addr_out <= cyc_addr;
				dma_cycle_out <= dma_sel;
			end
			if (wr_act)
				reg_wdata_out <= wr_word;
		end
	end

	// Status pins toward the host
	logic irq_n_reg, wide_n_reg, dma_request_out_reg;
	always_ff @(posedge mclk_in)
	begin
		if (rst)
		begin
			irq_n_reg <= 1'b1;
			wide_n_reg <= 1'b1;
			dma_request_out_reg <= 1'b0;
		end
		else
		begin
			irq_n_reg <= !irq_request_in;
			wide_n_reg <= !((rd_act || wr_act) && wide_hit);
			dma_request_out_reg <= dma_request_in ^ dma_request_out_active_low_in;
		end
	end
	assign bus.irq_out_n = irq_n_reg;
	assign bus.wide_cycle_indicator_n = wide_n_reg;
	assign bus.dma_request_out = dma_request_out_reg;

	// Terminal count and refresh edge detection
	logic tc_active, tc_prev_reg, refex_prev_reg;
	assign tc_active = tc_s ^ tc_active_low_in;
	always_ff @(posedge mclk_in)
	begin
		if (rst)
		begin
			tc_prev_reg <= 1'b1; // No false count while the pin chain settles
			refex_prev_reg <= 1'b1;
			terminal_count_out <= 1'b0;
			refresh_event_out <= 1'b0;
			fast_timing_out <= 1'b0;
		end
		else
		begin
			tc_prev_reg <= tc_active;
			refex_prev_reg <= refex_n_s;
			terminal_count_out <= tc_active && !tc_prev_reg;
			refresh_event_out <= refex_prev_reg && !refex_n_s;
			fast_timing_out <= !tmg_s && !mux_mode_in;
		end
	end

	// Reset pin level seen by the device, for the user side
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			hw_reset_seen_out <= 1'b0;
		else
			hw_reset_seen_out <= !hwrst_n_s;
	end
endmodule
`default_nettype wire

// File: tb/host_bus_asserts.sv
// Checker on the pins joining the host end and the device end.
// Assumes it is instantiated beside the host_bus_if instance.
`timescale 1ns/1ns
`default_nettype none
module host_bus_asserts (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic hw_reset_n,
	input wire logic chip_select_n,
	input wire logic dma_ack_n,
	input wire logic write_or_rw_sense,
	input wire logic read_or_data_strobe,
	input wire logic irq_out_n,
	input wire logic wide_cycle_indicator_n,
	input wire logic dev_low_oe,
	input wire logic dev_up_oe
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic sel_now;
	logic rd_now;
	logic [4:0] rd_hist_reg;
	logic [4:0] sel_hist_reg;
	// Select and read qualifiers seen at the pins
	assign sel_now = !chip_select_n || !dma_ack_n;
	assign rd_now = sel_now && !read_or_data_strobe && write_or_rw_sense;
	// Short history covering the device's synchroniser lag
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			rd_hist_reg <= 5'h00;
			sel_hist_reg <= 5'h00;
		end
		else
		begin
			rd_hist_reg <= {rd_hist_reg[3:0], rd_now};
			sel_hist_reg <= {sel_hist_reg[3:0], sel_now};
		end
	end
	sequence read_start_s;
		$fell(read_or_data_strobe) && write_or_rw_sense && sel_now && hw_reset_n;
	endsequence
	sequence drive_late_s;
		!dev_low_oe ##1 !dev_low_oe ##[1:4] dev_low_oe;
	endsequence
	AST_READ_ANSWER: assert property (read_start_s |-> drive_late_s)
		else $error("read strobe not answered in time");
	AST_READ_ONLY_DRIVE: assert property (dev_low_oe |-> (|rd_hist_reg))
		else $error("data driven outside a read");
	AST_UPPER_WIDE: assert property (dev_up_oe |-> dev_low_oe && !wide_cycle_indicator_n)
		else $error("upper byte driven without wide access");
	AST_WIDE_SELECTED: assert property ($fell(wide_cycle_indicator_n) |-> (|sel_hist_reg))
		else $error("wide indicator without a selected cycle");
	AST_RESET_QUIET: assert property (!hw_reset_n [*4] |-> irq_out_n && wide_cycle_indicator_n
		&& !dev_low_oe && !dev_up_oe)
		else $error("device active while reset pin low");
	AST_IDLE_QUIET: assert property ((chip_select_n && dma_ack_n) [*6] |-> !dev_low_oe
		&& !dev_up_oe && wide_cycle_indicator_n)
		else $error("device active while not selected");
	AST_OE_HOLD: assert property ($rose(dev_low_oe) |=> dev_low_oe [*3])
		else $error("read data drive too short");
	AST_WRITE_QUIET: assert property (!write_or_rw_sense [*6] |-> !dev_low_oe)
		else $error("data driven during a write");
endmodule
`default_nettype wire

// File: tb/tb.sv
// Bench joining host end and device end, with a register array on the
// device user side. Assumes a 20 MHz clock and synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic mclk_in, rst_n_in, moto, mux, fast, dev_rst, valid, wr, dma, wide, tc, ref_n;
	logic wen, swap, dma_request_out_lo, tc_lo, irq_req, dma_request_out_req, wseen;
	logic ready, rsp_v, irq_s, dma_request_out_s, wide_s, wr_p, dma_c, ref_p, fast_o, rst_seen;
	logic rd_p, tc_p, rseen;
	logic [2:0] addr, ra;
	logic [15:0] wdata, rsp, rdata, wd_o, got;
	logic [15:0] mem [0:7];
	logic [31:0] lfsr;
	int bad_count, total_checks, pulses, tc_pulses;
	host_bus_if host_bus_if_inst ();
	host_bus_host host_bus_host_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.bus(host_bus_if_inst.host), .motorola_mode_in(moto), .mux_mode_in(mux),
		.fast_timing_in(fast), .device_reset_in(dev_rst), .cmd_valid_in(valid),
		.cmd_write_in(wr), .cmd_dma_in(dma), .cmd_wide_in(wide), .cmd_addr_in(addr),
		.cmd_wdata_in(wdata), .tc_level_in(tc), .refresh_n_in(ref_n), .cmd_ready_out(ready),
		.rsp_valid_out(rsp_v), .rsp_rdata_out(rsp), .irq_out(irq_s),
		.dma_request_seen_out(dma_request_out_s), .wide_cycle_seen_out(wide_s));
	host_bus_device host_bus_device_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.bus(host_bus_if_inst.device), .motorola_mode_in(moto), .mux_mode_in(mux),
		.wide_enable_in(wen), .swap_bytes_in(swap), .dma_request_out_active_low_in(dma_request_out_lo),
		.tc_active_low_in(tc_lo), .irq_request_in(irq_req), .dma_request_in(dma_request_out_req),
		.reg_rdata_in(rdata), .reg_addr_out(ra), .reg_wdata_out(wd_o), .reg_write_out(wr_p),
		.reg_read_out(rd_p), .dma_cycle_out(dma_c), .terminal_count_out(tc_p),
		.refresh_event_out(ref_p), .fast_timing_out(fast_o), .hw_reset_seen_out(rst_seen));
	host_bus_asserts host_bus_asserts_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.hw_reset_n(host_bus_if_inst.hw_reset_n), .chip_select_n(host_bus_if_inst.chip_select_n),
		.dma_ack_n(host_bus_if_inst.dma_ack_n), .irq_out_n(host_bus_if_inst.irq_out_n),
		.write_or_rw_sense(host_bus_if_inst.write_or_rw_sense),
		.read_or_data_strobe(host_bus_if_inst.read_or_data_strobe),
		.wide_cycle_indicator_n(host_bus_if_inst.wide_cycle_indicator_n),
		.dev_low_oe(host_bus_if_inst.dev_low_oe), .dev_up_oe(host_bus_if_inst.dev_up_oe));
	// Register array answering the device user side
	assign rdata = mem[ra];
	always @(posedge mclk_in)
		if (wr_p === 1'b1) mem[ra] <= wd_o;
	// Free-running clock
	initial
	begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#2;
	endtask
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Upper lane reads the pull-ups when the host asks wide and the device stays off
	function automatic logic [15:0] expect_rd(input logic full, input logic wd,
		input logic [15:0] s);
		return full ? s : {(wd ? host_bus_pkg::BUS_PULLUP : 8'h00), s[7:0]};
	endfunction
	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One host command, waiting for the host end to be idle again
	task automatic bus_cycle(input logic w, input logic d, input logic wd,
		input logic [2:0] a, input logic [15:0] v);
		int n;
		tick(1);
		n = 0;
		while (ready !== 1'b1 && n < 100)
		begin
			tick(1);
			n++;
		end
		if (n >= 100) bad_count++;
		{valid, wr, dma, wide, addr, wdata} = {1'b1, w, d, wd, a, v};
		tick(1);
		valid = 1'b0;
		got = 16'hxxxx;
		wseen = 1'b0;
		rseen = 1'b0;
		n = 0;
		while (ready !== 1'b1 && n < 100)
		begin
			if (rsp_v === 1'b1) got = rsp;
			if (wide_s === 1'b1) wseen = 1'b1;
			if (rd_p === 1'b1) rseen = 1'b1;
			tick(1);
			n++;
		end
		if (n >= 100) bad_count++;
	endtask
	task automatic round_trip(input logic wd, input logic d, input logic [2:0] a,
		input logic [15:0] v);
		logic hit, full;
		hit = wen && (a == host_bus_pkg::DATA_REG_ADDR);
		full = wd && hit;
		bus_cycle(1'b1, d, wd, a, v);
		chk1(rseen, 1'b0);
		// The user-side write strobe trails the host's idle by one cycle
		tick(3);
		chk16(expect_rd(full, 1'b0, mem[a]), expect_rd(full, 1'b0, v));
		bus_cycle(1'b0, d, wd, a, 16'h0000);
		chk16(got, expect_rd(full, wd, v));
		chk1(rseen, 1'b1);
		chk1(wseen, hit);
		chk1(dma_c, d);
	endtask
	// Watchdog well beyond the expected run length
	initial
	begin
		#2000000;
		bad_count++;
		wrap_up();
	end
	// Main sequence
	initial
	begin
		{rst_n_in, moto, mux, fast, dev_rst, valid, wr, dma, wide, tc, ref_n} = 11'h001;
		{wen, swap, dma_request_out_lo, tc_lo, irq_req, dma_request_out_req, addr, wdata} = 25'h0;
		lfsr = 32'hf6fd2824;
		bad_count = 0;
		total_checks = 0;
		foreach (mem[i]) mem[i] = 16'h0000;
		tick(6);
		rst_n_in = 1'b1;
		tick(6);
		// Random round trips in every bus style, with a wide data-register access first
		for (int m = 0; m < 4; m++)
		begin
			{mux, moto} = m[1:0];
			for (int k = 0; k < 8; k++)
			begin
				lfsr = lfsr_next(lfsr);
				wen = lfsr[4] | (k < 2);
				fast = lfsr[5] & !mux;
				tick(6);
				chk1(fast_o, fast);
				if (k == 2)
					round_trip(1'b0, 1'b1, host_bus_pkg::DATA_REG_ADDR, lfsr[31:16]);
				else
					round_trip(lfsr[3] | (k < 2), 1'b0, (k == 0) ? 3'h4 : lfsr[2:0],
						lfsr[31:16]);
			end
		end
		// Byte lanes exchanged on a wide write, then read back unswapped
		{wen, swap} = 2'h3;
		bus_cycle(1'b1, 1'b0, 1'b1, host_bus_pkg::DATA_REG_ADDR, 16'ha55a ^ lfsr[15:0]);
		swap = 1'b0;
		bus_cycle(1'b0, 1'b0, 1'b1, host_bus_pkg::DATA_REG_ADDR, 16'h0000);
		chk16(got, {lfsr[7:0] ^ 8'h5a, lfsr[15:8] ^ 8'ha5});
		// Interrupt and DMA request levels over both polarities
		for (int i = 0; i < 8; i++)
		begin
			{irq_req, dma_request_out_req, dma_request_out_lo} = i[2:0];
			tick(8);
			chk1(irq_s, irq_req);
			chk1(dma_request_out_s, dma_request_out_req ^ dma_request_out_lo);
		end
		// One refresh pulse per falling edge, none on the rise; terminal count
		// pulses once high-active, then once more when low-active sees the pin fall
		{tc, tc_lo} = 2'h2;
		pulses = 0;
		tc_pulses = 0;
		ref_n = 1'b0;
		repeat (10)
		begin
			tick(1);
			if (ref_p === 1'b1) pulses++;
			if (tc_p === 1'b1) tc_pulses++;
		end
		{ref_n, tc, tc_lo} = 3'h5;
		repeat (10)
		begin
			tick(1);
			if (ref_p === 1'b1) pulses++;
			if (tc_p === 1'b1) tc_pulses++;
		end
		chk1(pulses == 1, 1'b1);
		chk1(tc_pulses == 2, 1'b1);
		// Device reset pin
		dev_rst = 1'b1;
		tick(6);
		chk1(rst_seen, 1'b1);
		dev_rst = 1'b0;
		tick(6);
		chk1(rst_seen, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
